// file: hdl/dsc_chan_ctrl.sv
// DPLL channel state sequencing, lock flags and DCO steering control
// Contract
// RULE_01 - Crystal locks analog loop; references unqualified in free-run
// RULE_02 - Reference lost before history valid returns channel to free-run
// RULE_03 - Any valid reference moves free-run or holdover into acquisition
// RULE_04 - Wide bandwidth only while acquiring, normal bandwidth afterwards
// RULE_05 - Frequency and phase lock loss flags readable as status
// RULE_06 - History accumulates once frequency lock loss clears, when enabled
// RULE_07 - Reference lost with no other valid input enters holdover
// RULE_08 - History disabled: holdover uses signed offset over numerator
// RULE_09 - History enabled: offset until history valid, then history average
// RULE_10 - Entering holdover sets phase lock loss flag
// RULE_11 - Frequency lock loss flag frozen throughout holdover
// RULE_12 - Valid input in holdover leaves holdover, relocks without glitch
// RULE_13 - Closed loop steers digital numerator; otherwise analog numerator (here only with history enabled)
// RULE_14 - Steering enable may be set only while locked
// RULE_15 - Each step adds or subtracts 38-bit deviation word
// RULE_16 - Step register write 0 raises, 1 lowers frequency
// RULE_17 - Pin mode: trigger rising edge steps, direction pin 0 up
// RULE_18 - Trigger pulses over 100ns, rate under 5MHz, from driver
// RULE_19 - Clearing steering enable discards offset, restores numerator
// RULE_20 - Absolute mode uses written 40-bit feedback numerator directly
// RULE_21 - Denominator zero means two to the fortieth
// RULE_22 - Analog offset relative with history, direct without; readable back
// RULE_23 - Analog offset word is signed two's complement
// RULE_24 - New analog offset write drops remaining steps, feeds new value
// RULE_25 - Completion flag once offset fully fed into analog numerator
// RULE_26 - Four exclusive channel states, synchronous, readable by software
`timescale 1ns/10ps
`include "dsc_defs.svh"
module dsc_chan_ctrl
  import dsc_pkg::*;
#(
  parameter int HIST_CYCLES = `DSC_HIST_CYCLES
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [7:0]   s_awaddr,
  input  wire logic         s_awvalid,
  output logic              s_awready,
  input  wire logic [31:0]  s_wdata,
  input  wire logic [3:0]   s_wstrb,
  input  wire logic         s_wvalid,
  output logic              s_wready,
  output logic [1:0]        s_bresp,
  output logic              s_bvalid,
  input  wire logic         s_bready,
  input  wire logic [7:0]   s_araddr,
  input  wire logic         s_arvalid,
  output logic              s_arready,
  output logic [31:0]       s_rdata,
  output logic [1:0]        s_rresp,
  output logic              s_rvalid,
  input  wire logic         s_rready,
  input  wire dsc_det_t     det,
  input  wire logic [39:0]  tuning_word,
  input  wire logic         step_trigger_pin,
  input  wire logic         step_direction_pin,
  output dsc_state_t        chan_state,
  output logic              freq_lock_loss_flag,
  output logic              phase_lock_loss_flag,
  output logic              wide_bw_active,
  output logic              ref_qualified,
  output logic              xo_locked,
  output logic [39:0]       holdover_tuning_word,
  output logic [39:0]       eff_digital_numerator,
  output logic [39:0]       effective_analog_numerator,
  output logic [40:0]       eff_denominator,
  output logic              apll_feed_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Bus slave state
  logic        aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r, rdata_r, merged;
  logic [3:0]  w_strb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic        wr_go;
  // Software registers
  dsc_ctrl_t   ctrl_r;
  logic [37:0] fdev_r;
  logic [39:0] hoff_r, fbnum_r, den_r, abase_r;
  logic [31:0] feed_step_r;
  logic [15:0] feed_per_r;
  // Channel state
  dsc_state_t  state_r, state_nxt;
  logic        flock_r, plock_r, xo_lock_r, qual_r, wide_r;
  logic        lost, no_hist;
  logic [31:0] hist_cnt_r;
  logic        hist_valid_r;
  logic [39:0] hist_word_r, hist_diff;
  // Steering datapath
  logic [39:0] steer_off_r, step_mag, reg_delta, pin_delta, step_delta;
  logic        reg_step, pin_step, pin_neg, steer_go, dpll_act;
  logic [39:0] rem_r, rem_nxt, rem_mag, chunk, feed_delta, acc_r;
  logic [15:0] per_cnt_r;
  logic        tick, feed_on, done_r;

  // Address match for the write being committed
  function automatic logic wr_at(input logic [7:0] off);
    return wr_go && (aw_addr_r == off);
  endfunction

  assign s_awready = !aw_full_r && !bvalid_r;
  assign s_wready  = !w_full_r && !bvalid_r;
  assign s_arready = !rvalid_r;
  assign s_bvalid  = bvalid_r;
  assign s_bresp   = bresp_r;
  assign s_rvalid  = rvalid_r;
  assign s_rdata   = rdata_r;
  assign s_rresp   = rresp_r;
  // Commit once both halves are held and no response is pending
  assign wr_go     = aw_full_r && w_full_r && !bvalid_r;

  // ==========================================================
  // Write address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_awaddr;
      end
      else if (wr_go)
        aw_full_r <= 1'b0;
      if (s_wvalid && s_wready)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
      end
      else if (wr_go)
        w_full_r <= 1'b0;
    end
  end

  // Write response; unmapped or unaligned answers SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= 2'b00;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= (aw_addr_r[1:0] == 2'b00 &&
                   aw_addr_r <= `DSC_OFF_FEED_PER) ? 2'b00 : 2'b10;
    end
    else if (s_bready)
      bvalid_r <= 1'b0;
  end

  // Byte lanes merged over a zero word; only lo words and feed step honour them fully
  always_comb
  begin
    merged = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
      if (w_strb_r[i])
        merged[8*i +: 8] = w_data_r[8*i +: 8];
  end

  // ==========================================================
  // Read channel, one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'b00;
    end
    else if (s_arvalid && s_arready)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= 2'b00;
      rdata_r  <= 32'h0000_0000;
      case (s_araddr)
        `DSC_OFF_CTRL:      rdata_r <= {27'h0, ctrl_r};
        // RULE_05 lock flags as status bits
        // RULE_26 state readable by software
        `DSC_OFF_STATUS:    rdata_r <= {24'h0, xo_lock_r, done_r, wide_r,
                                        hist_valid_r, plock_r, flock_r,
                                        state_r};
        `DSC_OFF_STEP:      rdata_r <= 32'h0000_0000;
        `DSC_OFF_FDEV_LO:   rdata_r <= fdev_r[31:0];
        `DSC_OFF_FDEV_HI:   rdata_r <= {26'h0, fdev_r[37:32]};
        `DSC_OFF_HOFF_LO:   rdata_r <= hoff_r[31:0];
        `DSC_OFF_HOFF_HI:   rdata_r <= {24'h0, hoff_r[39:32]};
        `DSC_OFF_FBNUM_LO:  rdata_r <= fbnum_r[31:0];
        `DSC_OFF_FBNUM_HI:  rdata_r <= {24'h0, fbnum_r[39:32]};
        `DSC_OFF_DEN_LO:    rdata_r <= den_r[31:0];
        `DSC_OFF_DEN_HI:    rdata_r <= {24'h0, den_r[39:32]};
        `DSC_OFF_DNUM_LO:   rdata_r <= eff_digital_numerator[31:0];
        `DSC_OFF_DNUM_HI:   rdata_r <= {24'h0, eff_digital_numerator[39:32]};
        // RULE_22 effective analog numerator read back
        `DSC_OFF_ANUM_LO:   rdata_r <= effective_analog_numerator[31:0];
        `DSC_OFF_ANUM_HI:   rdata_r <= {24'h0,
                                        effective_analog_numerator[39:32]};
        `DSC_OFF_ABASE_LO:  rdata_r <= abase_r[31:0];
        `DSC_OFF_ABASE_HI:  rdata_r <= {24'h0, abase_r[39:32]};
        `DSC_OFF_FEED_STEP: rdata_r <= feed_step_r;
        `DSC_OFF_FEED_PER:  rdata_r <= {16'h0, feed_per_r};
        default:            rresp_r <= 2'b10;
      endcase
    end
    else if (s_rready)
      rvalid_r <= 1'b0;
  end

  // ==========================================================
  // Plain storage registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fdev_r      <= 38'h0;
      hoff_r      <= 40'h0;
      fbnum_r     <= 40'h0;
      den_r       <= 40'h0;
      abase_r     <= 40'h0;
      feed_step_r <= `DSC_FEED_STEP_RST;
      feed_per_r  <= `DSC_FEED_PER_RST;
    end
    else
    begin
      if (wr_at(`DSC_OFF_FDEV_LO))   fdev_r[31:0]   <= merged;
      if (wr_at(`DSC_OFF_FDEV_HI))   fdev_r[37:32]  <= merged[5:0];
      // RULE_23 offset kept as signed two's complement
      if (wr_at(`DSC_OFF_HOFF_LO))   hoff_r[31:0]   <= merged;
      if (wr_at(`DSC_OFF_HOFF_HI))   hoff_r[39:32]  <= merged[7:0];
      // RULE_20 absolute numerator used as written
      if (wr_at(`DSC_OFF_FBNUM_LO))  fbnum_r[31:0]  <= merged;
      if (wr_at(`DSC_OFF_FBNUM_HI))  fbnum_r[39:32] <= merged[7:0];
      if (wr_at(`DSC_OFF_DEN_LO))    den_r[31:0]    <= merged;
      if (wr_at(`DSC_OFF_DEN_HI))    den_r[39:32]   <= merged[7:0];
      if (wr_at(`DSC_OFF_ABASE_LO))  abase_r[31:0]  <= merged;
      if (wr_at(`DSC_OFF_ABASE_HI))  abase_r[39:32] <= merged[7:0];
      if (wr_at(`DSC_OFF_FEED_STEP)) feed_step_r    <= merged;
      if (wr_at(`DSC_OFF_FEED_PER))  feed_per_r     <= merged[15:0];
    end
  end

  // Control word; steering enable guarded by lock state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_r <= `DSC_CTRL_RST;
    else if (wr_at(`DSC_OFF_CTRL))
    begin
      ctrl_r <= merged[4:0];
      // RULE_14 a new enable outside lock is ignored
      if (!ctrl_r.steering_enable && state_r != dsc_lock)
        ctrl_r.steering_enable <= 1'b0;
    end
  end

  // ==========================================================
  // Channel state machine
  assign lost    = det.reference_loss && !det.ref_valid;
  assign no_hist = ctrl_r.history_enable && !hist_valid_r;
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      // RULE_03 valid input starts acquisition
      dsc_free: if (xo_lock_r && det.ref_valid) state_nxt = dsc_acq;
      dsc_acq:
        if (lost)
          state_nxt = no_hist ? dsc_free : dsc_hold;
        else if (det.acq_done)
          state_nxt = dsc_lock;
      // RULE_02 no history yet falls back to free-run
      // RULE_07 otherwise holdover
      dsc_lock:
        if (lost)
          state_nxt = no_hist ? dsc_free : dsc_hold;
        else if (det.reference_loss)
          state_nxt = dsc_acq;  // Another input is ready: switch
      // RULE_12 relock from holdover word, numerator stays continuous
      dsc_hold: if (det.ref_valid) state_nxt = dsc_acq;
      default:  state_nxt = dsc_free;
    endcase
  end

  // RULE_26 one of four states, clocked
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= dsc_free;
    else
      state_r <= state_nxt;
  end

  // RULE_01 xo lock, references unqualified in free-run
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xo_lock_r <= 1'b0;
      qual_r    <= 1'b0;
    end
    else
    begin
      xo_lock_r <= det.xo_valid;
      qual_r    <= state_nxt != dsc_free && det.ref_valid;
    end
  end

  // RULE_04 widened bandwidth only while acquiring
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wide_r <= 1'b0;
    else
      wide_r <= ctrl_r.fastlock_en && state_nxt == dsc_acq;
  end

  // ==========================================================
  // Lock loss flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flock_r <= 1'b1;
      plock_r <= 1'b1;
    end
    else
    begin
      // RULE_11 frequency flag frozen in holdover
      if (state_r != dsc_hold)
        flock_r <= !det.freq_lock;
      // RULE_10 phase flag forced on holdover entry
      if (state_nxt == dsc_hold)
        plock_r <= 1'b1;
      else
        plock_r <= !det.phase_lock;
    end
  end

  // RULE_06 history runs once frequency lock holds
  assign hist_diff = tuning_word - hist_word_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl_r.history_enable)
    begin
      hist_cnt_r   <= 32'h0;
      hist_valid_r <= 1'b0;
      hist_word_r  <= 40'h0;
    end
    else if (state_r == dsc_lock && !flock_r)
    begin
      if (hist_cnt_r == 32'h0)
        hist_word_r <= tuning_word;
      else
        hist_word_r <= hist_word_r +
          40'($signed(hist_diff) >>> `DSC_HIST_SHIFT);
      if (hist_cnt_r != 32'(HIST_CYCLES))
        hist_cnt_r <= hist_cnt_r + 32'h1;
      else
        hist_valid_r <= 1'b1;
    end
  end

  // ==========================================================
  // Steering step sources
  dsc_step_pin u_step_pin (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .enable     (ctrl_r.pin_mode),
    .trig_in    (step_trigger_pin),
    .dir_in     (step_direction_pin),
    .step_pulse (pin_step),
    .step_neg   (pin_neg)
  );

  // RULE_15 deviation word widened to numerator width
  // RULE_16 register write: 0 up, 1 down
  assign step_mag   = {2'b00, fdev_r};
  assign reg_step   = wr_at(`DSC_OFF_STEP) && w_strb_r[0];
  assign reg_delta  = !reg_step ? 40'h0 :
                      (w_data_r[0] ? 40'h0 - step_mag : step_mag);
  assign pin_delta  = !pin_step ? 40'h0 :
                      (pin_neg ? 40'h0 - step_mag : step_mag);
  // Both sources in one cycle sum, so no step is lost
  assign step_delta = reg_delta + pin_delta;
  assign steer_go   = ctrl_r.steering_enable && (reg_step || pin_step);
  // RULE_13 closed loop owns steering, else analog numerator when history is enabled
  assign dpll_act   = ctrl_r.dloop_used &&
                      (state_r == dsc_lock || state_r == dsc_acq);

  // RULE_19 disable clears offset; absolute write restarts from it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      steer_off_r <= 40'h0;
    else if ((wr_at(`DSC_OFF_CTRL) && !merged[`DSC_CTRL_STEER]) ||
             wr_at(`DSC_OFF_FBNUM_HI))
      steer_off_r <= 40'h0;
    else if (steer_go && dpll_act)
      steer_off_r <= steer_off_r + step_delta;
  end

  // ==========================================================
  // Analog relative feed: paced chunks of the offset word
  assign tick    = per_cnt_r == feed_per_r;
  assign rem_mag = rem_r[39] ? 40'h0 - rem_r : rem_r;
  assign chunk   = (rem_mag > {8'h0, feed_step_r}) ?
                   {8'h0, feed_step_r} : rem_mag;
  assign feed_delta = rem_r[39] ? 40'h0 - chunk : chunk;
  assign feed_on = ctrl_r.history_enable && !dpll_act && tick &&
                   rem_r != 40'h0;
  // RULE_24 fresh write replaces what is left
  always_comb
  begin
    rem_nxt = rem_r;
    if (wr_at(`DSC_OFF_HOFF_HI))
      rem_nxt = {merged[7:0], hoff_r[31:0]};
    else if (feed_on)
      rem_nxt = rem_r - feed_delta;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      per_cnt_r <= 16'h0;
      rem_r     <= 40'h0;
      acc_r     <= 40'h0;
      done_r    <= 1'b1;
    end
    else
    begin
      per_cnt_r <= tick ? 16'h0 : per_cnt_r + 16'h1;
      rem_r     <= rem_nxt;
      // RULE_13 out of closed loop, steps go into acc_r, which moves the analog numerator only with history enabled
      acc_r     <= acc_r + (feed_on ? feed_delta : 40'h0) +
                   ((steer_go && !dpll_act) ? step_delta : 40'h0);
      // RULE_25 done once the whole word is fed
      done_r    <= rem_nxt == 40'h0;
    end
  end

  // ==========================================================
  // Registered results
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      holdover_tuning_word       <= 40'h0;
      eff_digital_numerator      <= 40'h0;
      effective_analog_numerator <= 40'h0;
      eff_denominator            <= `DSC_DEN_MAX;
    end
    else
    begin
      // RULE_08 offset over numerator without valid history
      // RULE_09 history average once valid
      holdover_tuning_word <= (ctrl_r.history_enable && hist_valid_r) ?
                              hist_word_r : fbnum_r + hoff_r;
      eff_digital_numerator <= fbnum_r + steer_off_r;
      // RULE_22 relative feed with history, direct sum without
      effective_analog_numerator <= ctrl_r.history_enable ?
                                    abase_r + acc_r : abase_r + hoff_r;
      // RULE_21 zero denominator means the maximum
      eff_denominator <= (den_r == 40'h0) ? `DSC_DEN_MAX : {1'b0, den_r};
    end
  end

  assign chan_state           = state_r;
  assign freq_lock_loss_flag  = flock_r;
  assign phase_lock_loss_flag = plock_r;
  assign wide_bw_active       = wide_r;
  assign ref_qualified        = qual_r;
  assign xo_locked            = xo_lock_r;
  assign apll_feed_done       = done_r;

  // ==========================================================
  // Checks
  chk_free_unqual: assert property (  // RULE_01
    state_r == dsc_free |=> !qual_r || state_r != dsc_free)
    else $error("reference qualified in free-run");
  chk_lost_no_hist: assert property (  // RULE_02
    state_r == dsc_lock && lost && no_hist |=> state_r == dsc_free)
    else $error("lost reference without history not free-run");
  chk_ref_acquire: assert property (  // RULE_03
    state_r == dsc_hold && det.ref_valid |=> state_r == dsc_acq)
    else $error("holdover did not start acquisition");
  chk_bw_revert: assert property (  // RULE_04
    state_r == dsc_acq && det.acq_done && !lost |=> !wide_r)
    else $error("wide bandwidth kept after acquisition");
  chk_hold_entry: assert property (  // RULE_10
    state_r == dsc_lock && lost && !no_hist
    |=> state_r == dsc_hold && plock_r)
    else $error("holdover entry without phase loss flag");
  chk_freq_lock_loss_flag_frozen: assert property (  // RULE_11
    state_r == dsc_hold |=> $stable(flock_r))
    else $error("frequency flag changed in holdover");
  chk_step_up: assert property (  // RULE_16
    reg_step && !w_data_r[0] && !pin_step && steer_go && dpll_act
    |=> steer_off_r == $past(steer_off_r) + $past(step_mag))
    else $error("register step did not raise offset");
  chk_steer_clear: assert property (  // RULE_19
    wr_go && aw_addr_r == `DSC_OFF_CTRL && !merged[`DSC_CTRL_STEER]
    |=> steer_off_r == 40'h0 ##1 eff_digital_numerator == fbnum_r)
    else $error("offset not discarded on disable");
  chk_den_zero: assert property (  // RULE_21
    den_r == 40'h0 && $stable(den_r) |=> eff_denominator == `DSC_DEN_MAX)
    else $error("zero denominator not maximum");
  cov_hold: cover property (state_r == dsc_lock ##1 state_r == dsc_hold);
  cov_lock: cover property (state_r == dsc_acq ##1 state_r == dsc_lock);
  cov_feed: cover property (!done_r ##1 done_r);
  cov_pin:  cover property (pin_step && steer_go);
endmodule

// file: hdl/dsc_defs.svh
// Register offsets, field positions, reset values and counts of dsc
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
// ==========================================================
// Register byte offsets
`define DSC_OFF_CTRL      8'h00
`define DSC_OFF_STATUS    8'h04
`define DSC_OFF_STEP      8'h08
`define DSC_OFF_FDEV_LO   8'h0C
`define DSC_OFF_FDEV_HI   8'h10
`define DSC_OFF_HOFF_LO   8'h14
`define DSC_OFF_HOFF_HI   8'h18
`define DSC_OFF_FBNUM_LO  8'h1C
`define DSC_OFF_FBNUM_HI  8'h20
`define DSC_OFF_DEN_LO    8'h24
`define DSC_OFF_DEN_HI    8'h28
`define DSC_OFF_DNUM_LO   8'h2C
`define DSC_OFF_DNUM_HI   8'h30
`define DSC_OFF_ANUM_LO   8'h34
`define DSC_OFF_ANUM_HI   8'h38
`define DSC_OFF_ABASE_LO  8'h3C
`define DSC_OFF_ABASE_HI  8'h40
`define DSC_OFF_FEED_STEP 8'h44
`define DSC_OFF_FEED_PER  8'h48
// ==========================================================
// Control field positions and reset values
`define DSC_CTRL_HIST     0
`define DSC_CTRL_STEER    1
`define DSC_CTRL_PIN      2
`define DSC_CTRL_FAST     3
`define DSC_CTRL_DLOOP    4
`define DSC_CTRL_RST      5'h10
`define DSC_FEED_STEP_RST 32'h0000_0100
`define DSC_FEED_PER_RST  16'h0019
`define DSC_DEN_MAX       41'h100_0000_0000
// ==========================================================
// Timing: clock rate, pin pulse floor, history settle count
`define DSC_CLK_MHZ       25
`define DSC_PIN_PULSE_NS  100
`define DSC_PIN_PULSE_CYC ((`DSC_PIN_PULSE_NS*`DSC_CLK_MHZ+999)/1000)
`define DSC_HIST_CYCLES   65536
`define DSC_HIST_SHIFT    4
`endif

// file: hdl/dsc_pkg.sv
// Types shared by the dpll state and steering control block
package dsc_pkg;
  typedef enum logic [1:0] {
    dsc_free = 2'b00,
    dsc_acq  = 2'b01,
    dsc_lock = 2'b10,
    dsc_hold = 2'b11
  } dsc_state_t;

  typedef struct packed {
    logic dloop_used;
    logic fastlock_en;
    logic pin_mode;
    logic steering_enable;
    logic history_enable;
  } dsc_ctrl_t;

  typedef struct packed {
    logic xo_valid;
    logic ref_valid;
    logic reference_loss;
    logic freq_lock;
    logic phase_lock;
    logic acq_done;
  } dsc_det_t;
endpackage

// file: hdl/dsc_step_pin.sv
// Rising-edge step detector for the pin steering inputs
`timescale 1ns/10ps
module dsc_step_pin (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic enable,
  input  wire logic trig_in,
  input  wire logic dir_in,
  output logic      step_pulse,
  output logic      step_neg
);
  logic trig_prev_r;

  // ==========================================================
  // Edge history; resets high so a pin held high is no step
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trig_prev_r <= 1'b1;
    else
      trig_prev_r <= trig_in;
  end

  // RULE_18 pulse floor lets sampler see each edge
  // RULE_17 one step per rising edge
  assign step_pulse = enable && trig_in && !trig_prev_r;
  assign step_neg   = dir_in;  // Low raises, high lowers
endmodule

// file: tb/dsc_far.sv
// Far-side model: reference detector levels and step pins
`timescale 1ns/10ps
module dsc_far
  import dsc_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   good,
  input  wire logic   flk,
  input  wire logic   step_go,
  input  wire logic   step_dn,
  output dsc_det_t    det,
  output logic [39:0] tuning_word,
  output logic        step_trigger_pin,
  output logic        step_direction_pin
);
  logic [2:0] cnt_r = 3'h0;
  // ==========================================
  // Detector levels, frequency lock held apart
  assign det = {1'h1, good, !good, flk, good, good};
  assign tuning_word = 40'h00_0000_1000;
  assign step_direction_pin = step_dn;
  // pulse width, rate
  // High 120 ns then low 160 ns keeps the sampler safe
  assign step_trigger_pin = (cnt_r > 3'h3);
  always_ff @(posedge aclk)
    cnt_r <= (cnt_r != 3'h0) ? cnt_r - 3'h1 : {step_go, step_go, 1'h0};
endmodule

// file: tb/testbench.sv
// Self-checking bench for the channel state and steering block
`timescale 1ns/10ps
`include "dsc_defs.svh"
module testbench
  import dsc_pkg::*;
();
  // ==========================================
  // Signals
  logic aclk = 1'h0, aresetn = 1'h0, good = 1'h0, flk = 1'h0;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic s_arvalid = 1'h0, s_rready = 1'h0, step_go = 1'h0, step_dn = 1'h0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata, d, fb, dv, rnd = 32'h7210BE6A;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, r;
  logic [39:0] tuning_word, holdover_tuning_word, want;
  logic [39:0] eff_digital_numerator, effective_analog_numerator;
  logic [40:0] eff_denominator;
  logic step_trigger_pin, step_direction_pin, xo_locked, apll_feed_done;
  logic freq_lock_loss_flag, phase_lock_loss_flag;
  logic wide_bw_active, ref_qualified;
  dsc_det_t det;
  dsc_state_t chan_state;
  int failures = 0, n_compared = 0;
  dsc_chan_ctrl #(.HIST_CYCLES(8)) dsc_chan_ctrl_i (.*);
  dsc_far dsc_far_i (.*);
  // Free-running clock, 40 ns period
  initial
  begin
    forever #20 aclk = !aclk;
  end
  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [39:0] step(input logic [39:0] b, input logic n);
    return n ? b - {8'h00, dv} : b + {8'h00, dv};
  endfunction
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // A wait that ran out ends the run as a mismatch
  task automatic gone(input logic ok);
    if (!ok)
    begin
      failures++;
      stop_test();
    end
  endtask
  task automatic wst(input dsc_state_t s);
    for (int n = 0; n < 40 && chan_state !== s; n++)
      @(posedge aclk);
    gone(chan_state === s);
  endtask
  // Ready is sampled mid-cycle; it only moves on rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ra, rw, rb;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    rb = 1'h0;
    for (int n = 0; n < 50 && !rb; n++)
    begin
      @(negedge aclk);
      ra = s_awready && s_awvalid;
      rw = s_wready && s_wvalid;
      rb = s_bvalid;
      @(posedge aclk);
      if (ra)
        s_awvalid <= 1'h0;
      if (rw)
        s_wvalid <= 1'h0;
    end
    s_bready <= 1'h0;
    gone(rb);
    repeat (4) @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ra, rr;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    rr = 1'h0;
    for (int n = 0; n < 50 && !rr; n++)
    begin
      @(negedge aclk);
      ra = s_arready && s_arvalid;
      rr = s_rvalid;
      d = s_rdata;
      r = s_rresp;
      @(posedge aclk);
      if (ra)
        s_arvalid <= 1'h0;
    end
    s_rready <= 1'h0;
    gone(rr);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    wr(8'h00, 32'h16);
    rd(8'h00);
    chk(d, 32'h14);
    chk({xo_locked, ref_qualified}, 2'h2);
    chk(eff_denominator, `DSC_DEN_MAX);
    good <= 1'h1;
    flk <= 1'h1;
    wst(dsc_lock);
    rd(8'h04);
    chk(d[5:0], 6'h02);
    fb = lfsr(rnd);
    dv = lfsr(fb);
    wr(8'h1C, fb);
    wr(8'h20, 32'h0);
    wr(8'h0C, dv);
    wr(8'h00, 32'h16);
    want = {8'h00, fb};
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      rnd[0] = (i < 2) ? i[0] : rnd[0];
      want = step(want, rnd[0]);
      wr(8'h08, {31'h0, rnd[0]});
      chk(eff_digital_numerator, want);
    end
    step_dn <= 1'h1;
    step_go <= 1'h1;
    @(posedge aclk);
    step_go <= 1'h0;
    repeat (10) @(posedge aclk);
    chk(eff_digital_numerator, step(want, 1'h1));
    wr(8'h00, 32'h14);
    chk(eff_digital_numerator, {8'h00, fb});
    rd(8'h4C);
    chk(r, 2'h2);
    good <= 1'h0;
    wst(dsc_hold);
    flk <= 1'h0;
    repeat (4) @(posedge aclk);
    chk({freq_lock_loss_flag, phase_lock_loss_flag},
        2'h1);
    // Negative analog offset, then fed in at most two wide chunks
    rnd = lfsr(rnd);
    wr(8'h14, rnd);
    wr(8'h18, 32'hFF);
    wr(8'h44, 32'hFFFFFFFF);
    chk(holdover_tuning_word, 40'({8'h00, fb} + {8'hFF, rnd}));
    chk({apll_feed_done, effective_analog_numerator},
        {1'h0, 8'hFF, rnd});
    wr(8'h00, 32'h1D);
    repeat (60) @(posedge aclk);
    chk({apll_feed_done, effective_analog_numerator},
        {1'h1, 8'hFF, rnd});
    good <= 1'h1;
    flk <= 1'h1;
    wst(dsc_lock);
    chk(chan_state, dsc_lock);
    chk(wide_bw_active, 1'h0);
    stop_test();
  end
endmodule
